// file: rtl/ufc_regs.vh
// Register offsets, field positions, reset values and trigger tables of the UART FIFO control.
`ifndef UFC_REGS_VH
`define UFC_REGS_VH

`define UFC_OFS_DATA 8'h00
`define UFC_OFS_IEN 8'h04
`define UFC_OFS_IST 8'h08
`define UFC_OFS_FCTL 8'h0C
`define UFC_OFS_LST 8'h10
`define UFC_OFS_RXLVL 8'h14
`define UFC_OFS_TXLVL 8'h18
`define UFC_OFS_FLOWLO 8'h1C
`define UFC_OFS_FLOWHI 8'h20

`define UFC_IEN_RX_BIT 0
`define UFC_IEN_TX_BIT 1
`define UFC_FCTL_EN_BIT 0
`define UFC_FCTL_RXFLUSH_BIT 1
`define UFC_FCTL_TXFLUSH_BIT 2

`define UFC_LST_DR_BIT 0
`define UFC_LST_OE_BIT 1
`define UFC_LST_PE_BIT 2
`define UFC_LST_FE_BIT 3
`define UFC_LST_BI_BIT 4
`define UFC_LST_THRE_BIT 5
`define UFC_LST_TEMT_BIT 6
`define UFC_LST_FERR_BIT 7

`define UFC_RST_IEN 8'h00
`define UFC_RST_FEN 1'b0
`define UFC_RST_LVL 8'h00

`define UFC_IST_NONE 6'h01
`define UFC_IST_RX 6'h04
`define UFC_IST_TX 6'h02

`define UFC_RX_TRIG_00 8'h08
`define UFC_RX_TRIG_01 8'h10
`define UFC_RX_TRIG_10 8'h18
`define UFC_RX_TRIG_11 8'h1C
`define UFC_TX_TRIG_00 8'h10
`define UFC_TX_TRIG_01 8'h08
`define UFC_TX_TRIG_10 8'h18
`define UFC_TX_TRIG_11 8'h1E

`endif

// file: rtl/ufc_fifo.v
// Synchronous FIFO with occupancy count and flush, used for both directions.
module ufc_fifo #(
    parameter WIDTH = 11,
    parameter ADDR_W = 5
) (
    input wire core_clk,
    input wire reset,
    input wire flush,
    input wire push,
    input wire [WIDTH-1:0] push_data,
    input wire pop,
    output wire [WIDTH-1:0] head_data,
    output wire [ADDR_W:0] count,
    output wire full,
    output wire empty
);
    reg [WIDTH-1:0] mem [0:(1<<ADDR_W)-1];
    reg [ADDR_W-1:0] wr_ptr_q;
    reg [ADDR_W-1:0] rd_ptr_q;
    reg [ADDR_W:0] count_q;
    wire do_push;
    wire do_pop;

    assign full = (count_q == {1'b1, {ADDR_W{1'b0}}});
    assign empty = (count_q == {(ADDR_W+1){1'b0}});
    assign do_push = push & ~full;
    assign do_pop = pop & ~empty;
    assign head_data = mem[rd_ptr_q];
    assign count = count_q;

    always @(posedge core_clk) begin
        if (do_push) begin
            mem[wr_ptr_q] <= push_data;
        end
    end

    // Flush wins over a push or pop in the same cycle so the count logic restarts clean.
    always @(posedge core_clk) begin
        if (reset || flush) begin
            wr_ptr_q <= {ADDR_W{1'b0}};
            rd_ptr_q <= {ADDR_W{1'b0}};
            count_q <= {(ADDR_W+1){1'b0}};
        end else begin
            if (do_push) begin
                wr_ptr_q <= wr_ptr_q + 1'b1;
            end
            if (do_pop) begin
                rd_ptr_q <= rd_ptr_q + 1'b1;
            end
            if (do_push && !do_pop) begin
                count_q <= count_q + 1'b1;
            end else if (do_pop && !do_push) begin
                count_q <= count_q - 1'b1;
            end
        end
    end
endmodule // ufc_fifo

// file: rtl/ufc_level_sel.v
// Trigger threshold selection from the two-bit fields or the programmable level registers.
`include "ufc_regs.vh"
module ufc_level_sel (
    input wire [1:0] rx_sel,
    input wire [1:0] tx_sel,
    input wire [7:0] rx_level,
    input wire [7:0] tx_level,
    input wire [7:0] flow_low,
    input wire [7:0] flow_high,
    output reg [7:0] rx_thr,
    output reg [7:0] tx_thr
);
    wire override;

    assign override = |{rx_level, tx_level, flow_low, flow_high};

    always @* begin
        case (rx_sel)
            2'b00: rx_thr = `UFC_RX_TRIG_00;
            2'b01: rx_thr = `UFC_RX_TRIG_01;
            2'b10: rx_thr = `UFC_RX_TRIG_10;
            default: rx_thr = `UFC_RX_TRIG_11;
        endcase
        case (tx_sel)
            2'b00: tx_thr = `UFC_TX_TRIG_00;
            2'b01: tx_thr = `UFC_TX_TRIG_01;
            2'b10: tx_thr = `UFC_TX_TRIG_10;
            default: tx_thr = `UFC_TX_TRIG_11;
        endcase
        if (override) begin
            rx_thr = rx_level;
            tx_thr = tx_level;
        end
    end
endmodule // ufc_level_sel

// file: rtl/ufc_top.v
// UART FIFO control, transmit and receive ready interrupts and line status behind an APB slave.
//
// The APB slave port and the address map were decided locally.
`include "ufc_regs.vh"

// Behaviour
// (RQ1) Tx ready: holding register empty without FIFOs, FIFO empty with FIFOs.
// (RQ2) Tx ready enable resets to 0; setting it reports the source at level 3.
// (RQ3) Without FIFOs, rx ready follows whether the holding register holds data.
// (RQ4) With FIFOs, rx ready (level 2) holds while count is at or above trigger.
// (RQ5) Status register rx indication sets and clears with the rx trigger condition.
// (RQ6) Data ready sets on first byte into rx FIFO, clears when FIFO empties.
// (RQ7) Tx FIFO drained to empty interrupts; cleared by status read or tx write.
// (RQ8) Polled mode: host polls line status, tx and rx bits independent.
// (RQ9) Four line status bits give overrun, parity, framing or break.
// (RQ10) One bit shows tx FIFO empty, another FIFO and shift register empty.
// (RQ11) Summary bit shows any errored character held in rx FIFO.
// (RQ12) Rx trigger field codes select 8, 16, 24 or 28 bytes.
// (RQ13) Selected thresholds drive both interrupts and flow control outputs.
// (RQ14) Tx trigger field selects threshold; interrupt when count drops below.
// (RQ15) Tx trigger codes select 16, 8, 24 or 30 bytes.
// (RQ16) Writing 1 to tx flush empties tx FIFO; bit self clears, 0 does nothing.
// (RQ17) Writing 1 to rx flush empties rx FIFO; bit self clears, 0 does nothing.
// (RQ18) FIFO enable resets to 0; writing 1 enables both FIFOs together.
// (RQ19) Any nonzero level register makes level registers set both thresholds.
// (RQ20) Status read returns highest pending code; lower codes show on re-read.
// (RQ21) One interrupt output is high while an enabled ready source is pending.
module ufc_top #(
    parameter ADDR_W = 5
) (
    input wire core_clk,
    input wire reset,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire pready,
    output wire pslverr,
    output wire [7:0] tx_byte,
    output wire tx_byte_valid,
    input wire tx_byte_take,
    input wire tx_shift_busy,
    input wire [7:0] rx_byte,
    input wire rx_byte_strobe,
    input wire rx_parity_err,
    input wire rx_framing_err,
    input wire rx_break,
    output wire irq,
    output wire rx_flow_halt,
    output wire tx_flow_low
);
    localparam CW = ADDR_W + 1;

    reg [7:0] ien_q;
    reg fifo_en_q;
    reg [1:0] rx_trig_q;
    reg [1:0] tx_trig_q;
    reg [7:0] rx_level_q;
    reg [7:0] tx_level_q;
    reg [7:0] flow_low_q;
    reg [7:0] flow_high_q;
    reg overrun_q;
    reg tx_flag_q;
    reg [CW-1:0] err_cnt_q;
    reg [31:0] prdata_q;
    reg ist_tx_shown_q;
    reg lst_oe_shown_q;
    reg [31:0] rd_mux;
    reg [5:0] ist_code;

    wire apb_setup;
    wire apb_access;
    wire apb_wr;
    wire apb_rd;
    wire apb_setup_rd;
    wire [7:0] wbyte;
    wire [7:0] rx_thr;
    wire [7:0] tx_thr;
    wire [7:0] rx_cnt8;
    wire [7:0] tx_cnt8;
    wire [CW-1:0] rx_count;
    wire [CW-1:0] tx_count;
    wire rx_full;
    wire rx_empty;
    wire tx_full;
    wire tx_empty;
    wire [10:0] rx_head;
    wire [7:0] tx_head;
    wire rx_full_eff;
    wire tx_full_eff;
    wire rx_push;
    wire rx_pop;
    wire tx_push;
    wire tx_pop;
    wire rx_flush;
    wire tx_flush;
    wire push_err;
    wire pop_err;
    wire rx_pend;
    wire tx_pend;
    wire tx_flag_set;
    wire tx_flag_clr;
    wire [7:0] lst_val;

    function ufc_hit;
        input [7:0] addr;
        begin
            case (addr)
                `UFC_OFS_DATA, `UFC_OFS_IEN, `UFC_OFS_IST, `UFC_OFS_FCTL, `UFC_OFS_LST,
                `UFC_OFS_RXLVL, `UFC_OFS_TXLVL, `UFC_OFS_FLOWLO, `UFC_OFS_FLOWHI: ufc_hit = 1'b1;
                default: ufc_hit = 1'b0;
            endcase
        end
    endfunction

    // The slave answers every access at once; unmapped addresses answer with an error.
    assign apb_setup = psel & ~penable;
    assign apb_access = psel & penable;
    assign apb_wr = apb_access & pwrite & ufc_hit(paddr);
    assign apb_rd = apb_access & ~pwrite & ufc_hit(paddr);
    assign apb_setup_rd = apb_setup & ~pwrite;
    assign pready = 1'b1;
    assign pslverr = apb_access & ~ufc_hit(paddr);
    assign prdata = prdata_q;
    assign wbyte = pwdata[7:0];

    ufc_level_sel u_level_sel (
        .rx_sel(rx_trig_q),
        .tx_sel(tx_trig_q),
        .rx_level(rx_level_q),
        .tx_level(tx_level_q),
        .flow_low(flow_low_q),
        .flow_high(flow_high_q),
        .rx_thr(rx_thr),
        .tx_thr(tx_thr)
    ); // (RQ12) (RQ15) (RQ19)

    // Flush pulses exist only for the write cycle, so the control bits read back as 0.
    assign rx_flush = apb_wr && (paddr == `UFC_OFS_FCTL) && wbyte[`UFC_FCTL_RXFLUSH_BIT]; // (RQ17)
    assign tx_flush = apb_wr && (paddr == `UFC_OFS_FCTL) && wbyte[`UFC_FCTL_TXFLUSH_BIT]; // (RQ16)

    // Without FIFOs each direction behaves as a single holding register.
    assign rx_full_eff = fifo_en_q ? rx_full : ~rx_empty; // (RQ3)
    assign tx_full_eff = fifo_en_q ? tx_full : ~tx_empty; // (RQ1)

    assign rx_push = rx_byte_strobe & ~rx_full_eff;
    assign rx_pop = apb_rd && (paddr == `UFC_OFS_DATA) && !rx_empty;
    assign tx_push = apb_wr && (paddr == `UFC_OFS_DATA) && !tx_full_eff;
    assign tx_pop = tx_byte_take & ~tx_empty;
    assign push_err = rx_parity_err | rx_framing_err | rx_break;
    assign pop_err = |rx_head[10:8];

    ufc_fifo #(
        .WIDTH(11),
        .ADDR_W(ADDR_W)
    ) u_rx_fifo (
        .core_clk(core_clk),
        .reset(reset),
        .flush(rx_flush),
        .push(rx_push),
        .push_data({rx_break, rx_framing_err, rx_parity_err, rx_byte}),
        .pop(rx_pop),
        .head_data(rx_head),
        .count(rx_count),
        .full(rx_full),
        .empty(rx_empty)
    );

    ufc_fifo #(
        .WIDTH(8),
        .ADDR_W(ADDR_W)
    ) u_tx_fifo (
        .core_clk(core_clk),
        .reset(reset),
        .flush(tx_flush),
        .push(tx_push),
        .push_data(wbyte),
        .pop(tx_pop),
        .head_data(tx_head),
        .count(tx_count),
        .full(tx_full),
        .empty(tx_empty)
    );

    assign tx_byte = tx_head;
    assign tx_byte_valid = ~tx_empty;

    assign rx_cnt8 = {{(8-CW){1'b0}}, rx_count};
    assign tx_cnt8 = {{(8-CW){1'b0}}, tx_count};

    // Flow control uses the same thresholds as the interrupts.
    assign rx_flow_halt = fifo_en_q & (rx_cnt8 >= rx_thr); // (RQ13)
    assign tx_flow_low = fifo_en_q & (tx_cnt8 < tx_thr); // (RQ13)

    // Receive ready is a level; it drops as soon as the count falls under the trigger.
    assign rx_pend = fifo_en_q ? (rx_cnt8 >= rx_thr) : ~rx_empty; // (RQ3) (RQ4) (RQ5)

    // With FIFOs the transmit source is an event flag: it sets on a tx flush, or when a byte taken by
    // the shifter leaves the count below the trigger or drains the FIFO.
    assign tx_flag_set = fifo_en_q & ((tx_pop & ((tx_cnt8 <= tx_thr) |
                         (tx_count == {{(CW-1){1'b0}}, 1'b1}))) | tx_flush); // (RQ7) (RQ14)
    assign tx_flag_clr = tx_push | (apb_rd && (paddr == `UFC_OFS_IST) && ist_tx_shown_q); // (RQ7)
    assign tx_pend = fifo_en_q ? tx_flag_q : tx_empty; // (RQ1)

    always @(posedge core_clk) begin
        if (reset) begin
            tx_flag_q <= 1'b0;
        end else if (tx_flag_set) begin
            tx_flag_q <= 1'b1; // (RQ7)
        end else if (tx_flag_clr) begin
            tx_flag_q <= 1'b0; // (RQ7)
        end
    end

    // Only enabled sources reach the pin; with both enables low the host just polls.
    assign irq = (ien_q[`UFC_IEN_RX_BIT] & rx_pend) | (ien_q[`UFC_IEN_TX_BIT] & tx_pend); // (RQ21) (RQ8)

    always @* begin
        if (ien_q[`UFC_IEN_RX_BIT] && rx_pend) begin
            ist_code = `UFC_IST_RX; // (RQ4) (RQ5) (RQ20)
        end else if (ien_q[`UFC_IEN_TX_BIT] && tx_pend) begin
            ist_code = `UFC_IST_TX; // (RQ2) (RQ20)
        end else begin
            ist_code = `UFC_IST_NONE;
        end
    end

    // Errored characters held in the receive FIFO are counted for the summary bit.
    always @(posedge core_clk) begin
        if (reset || rx_flush) begin
            err_cnt_q <= {CW{1'b0}};
        end else if ((rx_push & push_err) && !(rx_pop & pop_err)) begin
            err_cnt_q <= err_cnt_q + 1'b1; // (RQ11)
        end else if ((rx_pop & pop_err) && !(rx_push & push_err)) begin
            err_cnt_q <= err_cnt_q - 1'b1; // (RQ11)
        end
    end

    // Overrun is sticky; a new overrun in the clearing cycle keeps the bit set.
    always @(posedge core_clk) begin
        if (reset) begin
            overrun_q <= 1'b0;
        end else if (rx_byte_strobe && rx_full_eff) begin
            overrun_q <= 1'b1; // (RQ9)
        end else if (apb_rd && (paddr == `UFC_OFS_LST) && lst_oe_shown_q) begin
            overrun_q <= 1'b0;
        end
    end

    assign lst_val[`UFC_LST_DR_BIT] = ~rx_empty; // (RQ6) (RQ8)
    assign lst_val[`UFC_LST_OE_BIT] = overrun_q; // (RQ9)
    assign lst_val[`UFC_LST_PE_BIT] = ~rx_empty & rx_head[8]; // (RQ9)
    assign lst_val[`UFC_LST_FE_BIT] = ~rx_empty & rx_head[9]; // (RQ9)
    assign lst_val[`UFC_LST_BI_BIT] = ~rx_empty & rx_head[10]; // (RQ9)
    assign lst_val[`UFC_LST_THRE_BIT] = tx_empty; // (RQ1) (RQ10)
    assign lst_val[`UFC_LST_TEMT_BIT] = tx_empty & ~tx_shift_busy; // (RQ10)
    assign lst_val[`UFC_LST_FERR_BIT] = fifo_en_q & (err_cnt_q != {CW{1'b0}}); // (RQ11)

    always @* begin
        case (paddr)
            `UFC_OFS_DATA: rd_mux = {24'h0000_00, rx_head[7:0]};
            `UFC_OFS_IEN: rd_mux = {24'h0000_00, ien_q};
            `UFC_OFS_IST: rd_mux = {24'h0000_00, {2{fifo_en_q}}, ist_code}; // (RQ20)
            `UFC_OFS_FCTL: rd_mux = {24'h0000_00, rx_trig_q, tx_trig_q, 3'b000, fifo_en_q};
            `UFC_OFS_LST: rd_mux = {24'h0000_00, lst_val}; // (RQ8)
            `UFC_OFS_RXLVL: rd_mux = {24'h0000_00, rx_level_q};
            `UFC_OFS_TXLVL: rd_mux = {24'h0000_00, tx_level_q};
            `UFC_OFS_FLOWLO: rd_mux = {24'h0000_00, flow_low_q};
            `UFC_OFS_FLOWHI: rd_mux = {24'h0000_00, flow_high_q};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // Read data is captured in the setup cycle; clear-on-read effects act on what was shown.
    always @(posedge core_clk) begin
        if (reset) begin
            prdata_q <= 32'h0000_0000;
            ist_tx_shown_q <= 1'b0;
            lst_oe_shown_q <= 1'b0;
        end else if (apb_setup_rd) begin
            prdata_q <= rd_mux;
            ist_tx_shown_q <= (ist_code == `UFC_IST_TX);
            lst_oe_shown_q <= overrun_q;
        end
    end

    always @(posedge core_clk) begin
        if (reset) begin
            ien_q <= `UFC_RST_IEN; // (RQ2)
            fifo_en_q <= `UFC_RST_FEN; // (RQ18)
            rx_trig_q <= 2'b00;
            tx_trig_q <= 2'b00;
            rx_level_q <= `UFC_RST_LVL;
            tx_level_q <= `UFC_RST_LVL;
            flow_low_q <= `UFC_RST_LVL;
            flow_high_q <= `UFC_RST_LVL;
        end else if (apb_wr) begin
            case (paddr)
                `UFC_OFS_IEN: ien_q <= wbyte; // (RQ2)
                `UFC_OFS_FCTL: begin
                    fifo_en_q <= wbyte[`UFC_FCTL_EN_BIT]; // (RQ18)
                    rx_trig_q <= wbyte[7:6]; // (RQ12)
                    tx_trig_q <= wbyte[5:4]; // (RQ14)
                end
                `UFC_OFS_RXLVL: rx_level_q <= wbyte; // (RQ19)
                `UFC_OFS_TXLVL: tx_level_q <= wbyte; // (RQ19)
                `UFC_OFS_FLOWLO: flow_low_q <= wbyte; // (RQ19)
                `UFC_OFS_FLOWHI: flow_high_q <= wbyte; // (RQ19)
                default: ien_q <= ien_q;
            endcase
        end
    end
endmodule // ufc_top

// file: testbench/ufc_top_properties.sv
// Port-level assertions for the UART FIFO control block.
`include "ufc_regs.vh"
module ufc_top_properties #(
    parameter ADDR_W = 5
) (
    input logic core_clk,
    input logic reset,
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [7:0] paddr,
    input logic [31:0] pwdata,
    input logic [31:0] prdata,
    input logic pslverr,
    input logic [7:0] tx_byte,
    input logic tx_byte_valid,
    input logic tx_byte_take,
    input logic irq,
    input logic rx_flow_halt,
    input logic tx_flow_low
);
    logic [7:0] ien_q;
    logic fen_q;
    logic wr;
    logic fcr_wr;
    logic [7:0] wbyte;
    assign wr = psel && penable && pwrite;
    assign fcr_wr = wr && paddr == `UFC_OFS_FCTL;
    assign wbyte = pwdata[7:0];
    // Shadow copies, since the enables are not visible at the ports.
    always @(posedge core_clk) begin
        if (reset) begin
            ien_q <= 8'h00;
            fen_q <= 1'b0;
        end else if (wr && paddr == `UFC_OFS_IEN) begin
            ien_q <= wbyte;
        end else if (fcr_wr) begin
            fen_q <= wbyte[0];
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    property p_irq_cause;
        irq |-> ien_q[1:0] != 2'b00;
    endproperty
    a_irq_cause: assert property (p_irq_cause)
        else $error("irq without enable");
    property p_rx_irq;
        ien_q[0] && rx_flow_halt |-> irq;
    endproperty
    a_rx_irq: assert property (p_rx_irq)
        else $error("rx trigger without irq");
    property p_flow_off;
        !fen_q |-> !rx_flow_halt && !tx_flow_low;
    endproperty
    a_flow_off: assert property (p_flow_off)
        else $error("flow output without FIFOs");
    property p_tx_load;
        wr && paddr == `UFC_OFS_DATA && !tx_byte_valid
            |=> tx_byte_valid && tx_byte == $past(wbyte);
    endproperty
    a_tx_load: assert property (p_tx_load)
        else $error("tx byte not loaded");
    property p_tx_hold;
        tx_byte_valid && !tx_byte_take && !fcr_wr |=> tx_byte_valid && $stable(tx_byte);
    endproperty
    a_tx_hold: assert property (p_tx_hold)
        else $error("tx head changed unasked");
    property p_tx_flush;
        fcr_wr && wbyte[2] |=> !tx_byte_valid;
    endproperty
    a_tx_flush: assert property (p_tx_flush)
        else $error("tx flush left data");
    property p_slverr;
        psel && penable && paddr > `UFC_OFS_FLOWHI |-> pslverr;
    endproperty
    a_slverr: assert property (p_slverr)
        else $error("unmapped access not refused");
    property p_rdata;
        psel && penable && !pwrite |=> $stable(prdata);
    endproperty
    a_rdata: assert property (p_rdata)
        else $error("read data moved");
endmodule // ufc_top_properties
bind ufc_top ufc_top_properties #(.ADDR_W(ADDR_W)) u_props (.core_clk, .reset, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pslverr, .tx_byte, .tx_byte_valid,
    .tx_byte_take, .irq, .rx_flow_halt, .tx_flow_low);

// file: testbench/ufc_shifter_model.sv
// Behavioural transmit and receive shift path facing the FIFO control block.
module ufc_shifter_model (
    input logic core_clk,
    input logic reset,
    input logic stall,
    input logic [7:0] tx_byte,
    input logic tx_byte_valid,
    output logic tx_byte_take,
    output logic tx_shift_busy,
    output logic [7:0] rx_byte,
    output logic rx_byte_strobe,
    output logic rx_parity_err,
    output logic rx_framing_err,
    output logic rx_break
);
    logic [2:0] busy_q;
    logic [7:0] last_sent;
    initial begin
        tx_byte_take = 1'b0;
        rx_byte = 8'h00;
        rx_byte_strobe = 1'b0;
        {rx_break, rx_framing_err, rx_parity_err} = 3'h0;
    end
    assign tx_shift_busy = busy_q != 3'h0;
    // Five cycles per byte keep the drain slow enough to watch.
    always @(posedge core_clk) begin
        tx_byte_take <= 1'b0;
        if (reset) begin
            busy_q <= 3'h0;
        end else if (busy_q != 3'h0) begin
            busy_q <= busy_q - 3'h1;
        end else if (tx_byte_valid && !stall && !tx_byte_take) begin
            tx_byte_take <= 1'b1;
            busy_q <= 3'h4;
            last_sent <= tx_byte;
        end
    end
    // Idle lines carry the inverse of the last byte, so stale data cannot pass.
    task automatic send_rx(input logic [7:0] b, input logic [2:0] e);
        @(posedge core_clk);
        rx_byte <= b;
        {rx_break, rx_framing_err, rx_parity_err} <= e;
        rx_byte_strobe <= 1'b1;
        @(posedge core_clk);
        rx_byte_strobe <= 1'b0;
        rx_byte <= ~b;
        {rx_break, rx_framing_err, rx_parity_err} <= ~e;
    endtask
endmodule // ufc_shifter_model

// file: testbench/test_uart_fifo_irq_control.sv
// Self-checking bench for the UART FIFO control block.
`include "ufc_regs.vh"
module test_uart_fifo_irq_control;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk, reset, psel, penable, pwrite, stall, pready, pslverr, err;
    logic [7:0] paddr, tx_byte, rx_byte;
    logic [31:0] pwdata, prdata, rd;
    logic tx_byte_valid, tx_byte_take, tx_shift_busy, rx_byte_strobe, irq;
    logic rx_parity_err, rx_framing_err, rx_break, rx_flow_halt, tx_flow_low;
    int n_mismatch, checked, cyc;
    typedef struct {bit tx; bit [1:0] code; int n; bit exp;} ufc_row_t;
    ufc_row_t rows[14] = '{'{0, 0, 8, 1}, '{0, 0, 7, 0}, '{0, 1, 16, 1}, '{0, 1, 15, 0},
        '{0, 2, 24, 1}, '{0, 2, 23, 0}, '{0, 3, 28, 1}, '{0, 3, 27, 0}, '{1, 0, 15, 1},
        '{1, 0, 16, 0}, '{1, 1, 8, 0}, '{1, 1, 7, 1}, '{1, 3, 29, 1}, '{1, 3, 30, 0}};
    ufc_top #(.ADDR_W(5)) dut (.core_clk, .reset, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .tx_byte, .tx_byte_valid, .tx_byte_take,
        .tx_shift_busy, .rx_byte, .rx_byte_strobe, .rx_parity_err, .rx_framing_err,
        .rx_break, .irq, .rx_flow_halt, .tx_flow_low);
    ufc_shifter_model sh (.core_clk, .reset, .stall, .tx_byte, .tx_byte_valid,
        .tx_byte_take, .tx_shift_busy, .rx_byte, .rx_byte_strobe, .rx_parity_err,
        .rx_framing_err, .rx_break);
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end
    task tally_and_finish;
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // The wait is open-ended on purpose; the global timeout ends a hang.
    task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h00_0000, d};
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rdchk(input string nm, input logic [7:0] a, input logic [7:0] exp);
        apb(1'b0, a, 8'h00);
        chk(nm, rd, {24'h00_0000, exp});
    endtask
    task drain;
        while (tx_byte_valid === 1'b1 || tx_shift_busy === 1'b1) @(posedge core_clk);
        @(negedge core_clk);
    endtask
    initial begin
        {reset, stall, psel, penable, pwrite, paddr, pwdata} = {3'h4, 42'h0};
        {n_mismatch, checked, cyc} = 0;
        repeat (16) @(posedge core_clk);
        reset <= 1'b0;
        rdchk("ien", `UFC_OFS_IEN, 8'h00);
        rdchk("fctl", `UFC_OFS_FCTL, 8'h00);
        rdchk("ist", `UFC_OFS_IST, 8'h01);
        rdchk("lst", `UFC_OFS_LST, 8'h60);
        apb(1'b1, `UFC_OFS_IEN, 8'h03);
        rdchk("ist_tx", `UFC_OFS_IST, 8'h02);
        chk("irq_tx", irq, 1);
        sh.send_rx(8'hA5, 3'h0);
        rdchk("ist_rx", `UFC_OFS_IST, 8'h04);
        rdchk("lst_dr", `UFC_OFS_LST, 8'h61);
        rdchk("rx_data", `UFC_OFS_DATA, 8'hA5);
        rdchk("ist_again", `UFC_OFS_IST, 8'h02);
        stall <= 1'b1;
        apb(1'b1, `UFC_OFS_DATA, 8'h3C);
        rdchk("ist_full", `UFC_OFS_IST, 8'h01);
        rdchk("lst_full", `UFC_OFS_LST, 8'h00);
        stall <= 1'b0;
        drain();
        chk("sent", sh.last_sent, 8'h3C);
        apb(1'b1, `UFC_OFS_IEN, 8'h00);
        foreach (rows[i]) begin
            apb(1'b1, `UFC_OFS_FCTL, rows[i].tx ? {4'h3, 4'h7} & {2'h0, rows[i].code, 4'hF}
                : {rows[i].code, 6'h07});
            stall <= rows[i].tx;
            repeat (rows[i].n) begin
                if (rows[i].tx) apb(1'b1, `UFC_OFS_DATA, 8'h11);
                else sh.send_rx(8'h22, 3'h0);
            end
            @(negedge core_clk);
            chk("flow", rows[i].tx ? tx_flow_low : rx_flow_halt, rows[i].exp);
            chk("polled", irq, 0);
        end
        rdchk("fctl_rd", `UFC_OFS_FCTL, 8'h31);
        apb(1'b1, `UFC_OFS_FCTL, 8'h31);
        chk("no_flush", tx_byte_valid, 1);
        apb(1'b1, `UFC_OFS_FCTL, 8'h35);
        stall <= 1'b0;
        @(negedge core_clk);
        chk("tx_flush", tx_byte_valid, 0);
        for (int k = 0; k < 3; k++) begin
            apb(1'b1, `UFC_OFS_FCTL, 8'h03);
            sh.send_rx(8'h5A, 3'h1 << k);
            rdchk("lst_err", `UFC_OFS_LST, 8'hE1 | (8'h04 << k));
        end
        apb(1'b1, `UFC_OFS_IEN, 8'h02);
        apb(1'b1, `UFC_OFS_FCTL, 8'h07);
        rdchk("ist_flush", `UFC_OFS_IST, 8'hC2);
        stall <= 1'b1;
        apb(1'b1, `UFC_OFS_DATA, 8'h71);
        apb(1'b1, `UFC_OFS_DATA, 8'h72);
        rdchk("ist_load", `UFC_OFS_IST, 8'hC1);
        stall <= 1'b0;
        drain();
        chk("sent2", sh.last_sent, 8'h72);
        chk("irq_drain", irq, 1);
        rdchk("ist_drain", `UFC_OFS_IST, 8'hC2);
        rdchk("ist_clr", `UFC_OFS_IST, 8'hC1);
        rdchk("lst_idle", `UFC_OFS_LST, 8'h60);
        apb(1'b1, `UFC_OFS_IEN, 8'h01);
        apb(1'b1, `UFC_OFS_RXLVL, 8'h03);
        apb(1'b1, `UFC_OFS_FCTL, 8'h03);
        repeat (2) sh.send_rx(8'h33, 3'h0);
        @(negedge core_clk);
        chk("lvl_below", rx_flow_halt, 0);
        sh.send_rx(8'h34, 3'h0);
        @(negedge core_clk);
        chk("lvl_at", rx_flow_halt, 1);
        rdchk("ist_lvl", `UFC_OFS_IST, 8'hC4);
        rdchk("rx_pop", `UFC_OFS_DATA, 8'h33);
        rdchk("ist_below", `UFC_OFS_IST, 8'hC1);
        chk("irq_below", irq, 0);
        apb(1'b1, `UFC_OFS_RXLVL, 8'h00);
        apb(1'b0, 8'h40, 8'h00);
        chk("slverr", err, 1);
        chk("rd_unmapped", rd, 0);
        tally_and_finish();
    end
endmodule // test_uart_fifo_irq_control
